//--- logic/tlia_consts.svh
// Purpose: Named constants of the two-level interrupt arbiter.
// Assumes: Register numbers are word indices; byte address is index * 4.
// Notes:   Vectors and offsets are 16-bit program/data words.
`ifndef TLIA_CONSTS_SVH
`define TLIA_CONSTS_SVH

// Register word indices
`define TLIA_IDX_STATUS    16'h7000
`define TLIA_IDX_MASK      16'h7004
`define TLIA_IDX_PEND      16'h7006
`define TLIA_IDX_SYSVEC    16'h701E
`define TLIA_IDX_SRC_BASE  16'h7070

// Field positions
`define TLIA_GMASK_BIT     9
`define TLIA_SRC_FLAG_BIT  0
`define TLIA_SRC_EN_BIT    1

// Reset values
`define TLIA_RST_GMASK     1'b1
`define TLIA_RST_LINEMASK  6'h00

// Core vector locations
`define TLIA_VEC_RESET     16'h0000
`define TLIA_VEC_EMU       16'h0026
`define TLIA_VEC_NMI       16'h0024
`define TLIA_VEC_TRAP      16'h0022
`define TLIA_VEC_LINE_BASE 16'h0002
`define TLIA_VEC_LINE_STEP 16'h0002

// Core ranks
`define TLIA_RANK_RESET    4'h1
`define TLIA_RANK_EMU      4'h2
`define TLIA_RANK_NMI      4'h3
`define TLIA_RANK_LINE1    4'h4
`define TLIA_RANK_SOFT     4'hF

// Peripheral vector offsets
`define TLIA_OFS_PHANTOM   16'h0000
`define TLIA_OFS_NMI       16'h0002
`define TLIA_OFS_EXT1      16'h0001
`define TLIA_OFS_EXT2      16'h0011
`define TLIA_OFS_EXT3      16'h001F
`define TLIA_OFS_SPI       16'h0005
`define TLIA_OFS_RX        16'h0006
`define TLIA_OFS_TX        16'h0007
`define TLIA_OFS_WDT       16'h0010
`define TLIA_OFS_PDP       16'h0020

`endif

//--- logic/tlia_pkg.sv
// Purpose: Types of the two-level interrupt arbiter.
// Assumes: Eight sources on core line one, six maskable core lines.
// Notes:   All state of the top module is one packed struct.
`default_nettype none
package tlia_pkg;

	typedef struct packed {
		logic [7:0]  srcSync1;
		logic [7:0]  srcSync2;
		logic [7:0]  srcPrev;
		logic        nmiSync1;
		logic        nmiSync2;
		logic        nmiPrev;
		logic [7:0]  srcFlag;
		logic [7:0]  srcEnable;
		logic [5:0]  linePrev;
		logic [5:0]  linePending;
		logic [5:0]  lineMask;
		logic        globalMask;
		logic        resetPending;
		logic        emuPending;
		logic        trapPending;
		logic        nmiPending;
		logic        nmiActive;
		logic        nmiReport;
		logic        ackValid;
		logic [15:0] ackVector;
		logic [3:0]  ackRank;
		logic        vectorCall;
		logic [15:0] rdData;
		logic        rdErr;
		logic        rdClr;
		logic [2:0]  rdClrIdx;
	} tlia_state_s;

endpackage : tlia_pkg
`default_nettype wire

//--- logic/tlia_arbiter.sv
// Purpose: Two-level interrupt arbiter with APB register access.
// Assumes: Sources and nmi pin are asynchronous; core lines 2..6 and core
//          handshake inputs are on core_clk.
// Notes:   Registers are word indices; byte address is index * 4.
// Behaviour
// - Core lines ranked one to nine, highest rank acknowledged first.
// - Reset 1, emulator 2, nonmaskable 3, lines one to six at 4..9.
// - System module feeds lines one, five, six, nmi; event manager 2-4.
// - Sources on a maskable line have fixed priority; highest served.
// - Each source has flag and enable; request sets its flag.
// - Flag and enable together compete; only highest is forwarded.
// - Forwarded request sets the line's bit in the pending register.
// - Maskable ack needs highest pending, global mask 0, line mask 1.
// - Global mask is bit 9 of status word zero; 1 disables.
// - Global mask set at reset and on acks except soft trap.
// - Line mask register has one bit per line; 1 unmasks.
// - Maskable ack inserts the vector call at the line's vector.
// - Vector register returns offset naming the requesting source.
// - Vector read with no source requesting returns phantom 0000h.
// - Reset rank 1 vector 0000h; emulator trap rank 2 vector 0026h.
// - Nonmaskable line rank 3, vector 0024h, offset 0002h.
// - External requests one to three report 0001h, 0011h, 001Fh.
// - Serial peripheral, receive, transmit report 0005h, 0006h, 0007h.
// - Nonmaskable outranks maskable; blocked only by active nmi, reset, emulator trap.
// - Soft trap goes to 22h and leaves the global mask alone.
//
// The APB slave port was left to the implementer.
`include "tlia_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tlia_arbiter #(
	parameter int NUM_SRC   = 8,               // Sources on core line one
	parameter int NUM_LINES = 6                // Maskable core lines
) (
	input  wire logic        core_clk,         // System clock, 200 MHz
	input  wire logic        reset,            // Async reset, active high
	input  wire logic        psel,             // APB select
	input  wire logic        penable,          // APB access phase
	input  wire logic        pwrite,           // APB write
	input  wire logic [31:0] paddr,            // APB byte address
	input  wire logic [31:0] pwdata,           // APB write data
	output logic      [31:0] prdata,           // APB read data
	output logic             pready,           // APB ready
	output logic             pslverr,          // APB error, unmapped
	input  wire logic [7:0]  sourceRequest,    // Line one sources, async
	input  wire logic        nmiRequestN,      // Nonmaskable pin, low
	input  wire logic [4:0]  lineRequest,      // Lines two to six, levels
	input  wire logic        emuTrap,          // Emulator trap pulse
	input  wire logic        softTrap,         // Soft trap pulse
	input  wire logic        nmiReturn,        // Nmi service done pulse
	input  wire logic        coreReady,        // Core can take an ack
	output logic             ackValid,         // Ack pulse
	output logic      [15:0] ackVector,        // Core vector of the ack
	output logic      [3:0]  ackRank,          // Core rank of the ack
	output logic             vectorCall,       // Vector call insert pulse
	output logic      [5:0]  linePending,      // Pending lines
	output logic             globalMask        // Global mask state
);

	tlia_pkg::tlia_state_s q;
	tlia_pkg::tlia_state_s next_q;

	// Offset of each line-one source, in fixed priority order
	function automatic logic [15:0] srcOffset(input logic [2:0] idx);
		logic [15:0] ofs;
		ofs = `TLIA_OFS_PHANTOM;
		case (idx)
			3'h0: ofs = `TLIA_OFS_EXT1;
			3'h1: ofs = `TLIA_OFS_EXT2;
			3'h2: ofs = `TLIA_OFS_EXT3;
			3'h3: ofs = `TLIA_OFS_SPI;
			3'h4: ofs = `TLIA_OFS_RX;
			3'h5: ofs = `TLIA_OFS_TX;
			// Watchdog and drive protect close the chain
			3'h6: ofs = `TLIA_OFS_WDT;
			3'h7: ofs = `TLIA_OFS_PDP;
			default: ofs = `TLIA_OFS_PHANTOM;
		endcase
		return ofs;
	endfunction : srcOffset

	// Source, line and bus decode and request signals
	logic [NUM_SRC-1:0]   srcActive;
	logic [NUM_SRC-1:0]   srcRise;
	logic [NUM_SRC-1:0]   srcSel;
	logic [NUM_LINES-1:0] forwardReq;
	logic [NUM_LINES-1:0] lineRise;
	logic [NUM_LINES-1:0] lineEligible;
	logic [2:0]           winIdx;
	logic                 winValid;
	logic [2:0]           lineIdx;
	logic                 lineValid;
	logic [15:0]          wordIdx;
	logic                 addrOk;
	logic                 setupPhase;
	logic                 accessPhase;
	logic                 nmiFall;
	logic [15:0]          vecReadValue;
	logic                 selStatus;
	logic                 selMask;
	logic                 selPend;
	logic                 selVector;

	// Address split: word index, upper bits and lane bits must be zero
	assign wordIdx     = paddr[17:2];
	assign addrOk      = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
	assign setupPhase  = psel && !penable;
	assign accessPhase = psel && penable;

	// Register selects; a stray upper address bit selects nothing
	assign selStatus = addrOk && (wordIdx == `TLIA_IDX_STATUS);
	assign selMask   = addrOk && (wordIdx == `TLIA_IDX_MASK);
	assign selPend   = addrOk && (wordIdx == `TLIA_IDX_PEND);
	assign selVector = addrOk && (wordIdx == `TLIA_IDX_SYSVEC);

	// Per-source request edge and register select
	genvar gi;
	generate
		for (gi = 0; gi < NUM_SRC; gi++) begin : gSrc
			assign srcRise[gi]   = q.srcSync2[gi] && !q.srcPrev[gi];
			assign srcActive[gi] = q.srcFlag[gi] && q.srcEnable[gi];
			assign srcSel[gi]    = addrOk && (wordIdx ==
				`TLIA_IDX_SRC_BASE + 16'(gi));
		end
	endgenerate

	// Fixed source priority, lowest index wins
	// Top-down scan lets the last hit, the lowest index, win
	always_comb begin
		winIdx   = 3'h0;
		winValid = 1'b0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (srcActive[i]) begin
				winIdx   = 3'(i);
				winValid = 1'b1;
			end
		end
	end

	// Line one from system sources, others from peripheral inputs
	// Lines two to six come already arbitrated, two to four by the event manager
	assign forwardReq = {lineRequest, winValid};
	// Forwarded request edge marks line pending
	assign lineRise   = forwardReq & ~q.linePrev;
	// Nmi pin is active low, so the request is its falling edge
	assign nmiFall    = !q.nmiSync2 && q.nmiPrev;

	// Pending, unmasked and globally enabled lines qualify
	// A masked line stays pending and is taken once both masks open
	assign lineEligible = q.linePending & q.lineMask &
		{NUM_LINES{!q.globalMask}};

	// Lowest line number is the highest core rank
	// Same scan; line one at rank 4 beats the other lines
	always_comb begin
		lineIdx   = 3'h0;
		lineValid = 1'b0;
		for (int i = NUM_LINES - 1; i >= 0; i--) begin
			if (lineEligible[i]) begin
				lineIdx   = 3'(i);
				lineValid = 1'b1;
			end
		end
	end

	// Vector register answer, nmi report before line-one sources
	// Frozen in setup so a late source cannot change a read in flight
	always_comb begin
		vecReadValue = `TLIA_OFS_PHANTOM;
		if (q.nmiReport) begin
			vecReadValue = `TLIA_OFS_NMI;
		end else if (winValid) begin
			vecReadValue = srcOffset(winIdx);
		end else begin
			vecReadValue = `TLIA_OFS_PHANTOM;
		end
	end

	// Whole next state: bus, flags, pending lines and core acknowledge
	always_comb begin
		next_q = q;

		// Two flip-flop synchronisers; only the second stage is read
		// The first stage may go metastable, so no logic looks at it
		next_q.srcSync1 = sourceRequest;
		next_q.srcSync2 = q.srcSync1;
		next_q.srcPrev  = q.srcSync2;
		next_q.nmiSync1 = nmiRequestN;
		next_q.nmiSync2 = q.nmiSync1;
		next_q.nmiPrev  = q.nmiSync2;
		next_q.linePrev = forwardReq;
		next_q.ackValid   = 1'b0;
		next_q.vectorCall = 1'b0;
		next_q.rdClr      = 1'b0;

		// Setup phase: capture read data so prdata comes from a flop
		// Decoding here makes pslverr flop based as well
		if (setupPhase) begin
			next_q.rdErr  = 1'b1;
			next_q.rdData = 16'h0000;
			if (selStatus) begin
				next_q.rdData[`TLIA_GMASK_BIT] = q.globalMask;
				next_q.rdErr = 1'b0;
			end
			if (selMask) begin
				next_q.rdData[NUM_LINES-1:0] = q.lineMask;
				next_q.rdErr = 1'b0;
			end
			if (selPend) begin
				next_q.rdData[NUM_LINES-1:0] = q.linePending;
				next_q.rdErr = 1'b0;
			end
			if (selVector) begin
				next_q.rdData   = vecReadValue;
				next_q.rdErr    = pwrite;
				next_q.rdClr    = !pwrite && !q.nmiReport && winValid;
				next_q.rdClrIdx = winIdx;
			end
			for (int i = 0; i < NUM_SRC; i++) begin
				if (srcSel[i]) begin
					next_q.rdData[`TLIA_SRC_FLAG_BIT] = q.srcFlag[i];
					next_q.rdData[`TLIA_SRC_EN_BIT]   = q.srcEnable[i];
					next_q.rdErr = 1'b0;
				end
			end
		end else begin
			next_q.rdClr = q.rdClr && !accessPhase;
		end

		// Access phase: writes and read side effects take effect here
		// Clears are written first; hardware sets are ORed in after
		if (accessPhase && pwrite && !q.rdErr) begin
			if (wordIdx == `TLIA_IDX_STATUS) begin
				// Software sets and clears global mask
				next_q.globalMask = pwdata[`TLIA_GMASK_BIT];
			end
			if (wordIdx == `TLIA_IDX_MASK) begin
				next_q.lineMask = pwdata[NUM_LINES-1:0];
			end
			if (wordIdx == `TLIA_IDX_PEND) begin
				next_q.linePending = q.linePending &
					~pwdata[NUM_LINES-1:0];
			end
			for (int i = 0; i < NUM_SRC; i++) begin
				if (srcSel[i]) begin
					next_q.srcEnable[i] = pwdata[`TLIA_SRC_EN_BIT];
					if (pwdata[`TLIA_SRC_FLAG_BIT]) begin
						next_q.srcFlag[i] = 1'b0;
					end
				end
			end
		end
		if (accessPhase && !pwrite && selVector) begin
			if (q.rdClr) begin
				next_q.srcFlag[q.rdClrIdx] = 1'b0;
			end
			next_q.nmiReport = 1'b0;
		end

		// Hardware set wins over any clear this cycle
		next_q.srcFlag = next_q.srcFlag | srcRise;
		next_q.linePending = next_q.linePending | lineRise;

		// Event capture for the non-line requests
		// Pulses stay pending until taken, so a busy core loses none
		if (emuTrap) begin
			next_q.emuPending = 1'b1;
		end
		if (softTrap) begin
			next_q.trapPending = 1'b1;
		end
		if (nmiFall) begin
			next_q.nmiPending = 1'b1;
		end
		if (nmiReturn) begin
			next_q.nmiActive = 1'b0;
		end

		// Core acknowledge in rank order, one per cycle the core is ready
		// Limitation: lower ranks wait; only one ack leaves per edge
		if (coreReady) begin
			if (q.resetPending) begin
				next_q.resetPending = 1'b0;
				next_q.ackValid     = 1'b1;
				next_q.ackVector    = `TLIA_VEC_RESET;
				next_q.ackRank      = `TLIA_RANK_RESET;
				next_q.globalMask   = 1'b1;
			end else if (q.emuPending) begin
				next_q.emuPending = 1'b0;
				next_q.ackValid   = 1'b1;
				next_q.ackVector  = `TLIA_VEC_EMU;
				next_q.ackRank    = `TLIA_RANK_EMU;
				next_q.globalMask = 1'b1;
			end else if (q.nmiPending && !q.nmiActive) begin
				// Nmi above maskable, held off by active nmi
				next_q.nmiPending = 1'b0;
				next_q.nmiActive  = 1'b1;
				next_q.nmiReport  = 1'b1;
				next_q.ackValid   = 1'b1;
				next_q.ackVector  = `TLIA_VEC_NMI;
				next_q.ackRank    = `TLIA_RANK_NMI;
				next_q.globalMask = 1'b1;
			end else if (lineValid) begin
				next_q.linePending[lineIdx] = lineRise[lineIdx];
				next_q.ackValid   = 1'b1;
				next_q.vectorCall = 1'b1;
				next_q.ackVector  = `TLIA_VEC_LINE_BASE +
					16'(lineIdx) * `TLIA_VEC_LINE_STEP;
				// Lines one to six at ranks 4..9
				next_q.ackRank    = `TLIA_RANK_LINE1 + 4'(lineIdx);
				next_q.globalMask = 1'b1;
			end else if (q.trapPending) begin
				next_q.trapPending = 1'b0;
				next_q.ackValid    = 1'b1;
				next_q.ackVector   = `TLIA_VEC_TRAP;
				next_q.ackRank     = `TLIA_RANK_SOFT;
			end
		end
	end

	// State register; reset loads constants only
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			q              <= '0;
			// Idle high so a source held through reset raises no flag
			q.srcSync1     <= '1;
			q.srcSync2     <= '1;
			q.srcPrev      <= '1;
			q.nmiSync1     <= 1'b1;
			q.nmiSync2     <= 1'b1;
			q.nmiPrev      <= 1'b1;
			q.lineMask     <= `TLIA_RST_LINEMASK;
			q.globalMask   <= `TLIA_RST_GMASK;
			q.resetPending <= 1'b1;
		end else begin
			q <= next_q;
		end
	end

	// Outputs; the bus answers in the access phase with no wait state
	// Registers are 16 bits wide; the upper half of prdata reads zero
	assign pready      = accessPhase;
	assign pslverr     = accessPhase && q.rdErr;
	assign prdata      = {16'h0000, q.rdData};
	assign ackValid    = q.ackValid;
	assign ackVector   = q.ackVector;
	assign ackRank     = q.ackRank;
	assign vectorCall  = q.vectorCall;
	assign linePending = q.linePending;
	assign globalMask  = q.globalMask;

endmodule : tlia_arbiter
`default_nettype wire

//--- bench/tlia_arbiter_monitor.sv
// Purpose: Concurrent checks on the core side of the arbiter.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes:   Bound into every arbiter instance.
`timescale 1ns/100ps
`default_nettype none
module tlia_arbiter_monitor (
	input wire logic        core_clk,    // Clock
	input wire logic        reset,       // Reset
	input wire logic        coreReady,   // Core can take an ack
	input wire logic        ackValid,    // Ack pulse
	input wire logic [15:0] ackVector,   // Ack vector
	input wire logic [3:0]  ackRank,     // Ack rank
	input wire logic        vectorCall,  // Call insert pulse
	input wire logic [5:0]  linePending, // Pending lines
	input wire logic        globalMask   // Global mask
);
	// Every check runs on the core clock and sleeps in reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	chk_call_line: assert property (
		vectorCall |-> ackValid && ackRank inside {[4'h4:4'h9]})
		else $error("vector call outside a line ack");
	chk_line_vec: assert property (
		vectorCall |-> ackVector == 16'h0002 + {11'h0, ackRank - 4'h4, 1'b0})
		else $error("line vector does not follow its rank");
	chk_ack_mask: assert property (
		ackValid && ackRank != 4'hF |-> globalMask)
		else $error("ack left the global mask open");
	chk_mask_open: assert property (
		vectorCall |-> !$past(globalMask))
		else $error("line ack taken while globally masked");
	chk_pend_seen: assert property (
		vectorCall |-> ($past(linePending) & (6'h01 << (ackRank - 4'h4))) != 6'h00)
		else $error("line ack without a pending bit");
	chk_nmi_vec: assert property (
		ackValid && ackRank == 4'h3 |-> ackVector == 16'h0024 && !vectorCall)
		else $error("nonmaskable ack vector wrong");
	chk_reset_vec: assert property (
		ackValid && ackRank == 4'h1 |-> ackVector == 16'h0000)
		else $error("reset ack vector wrong");
	chk_emu_vec: assert property (
		ackValid && ackRank == 4'h2 |-> ackVector == 16'h0026)
		else $error("emulator ack vector wrong");
	chk_trap_keep: assert property (
		ackValid && ackRank == 4'hF |-> ackVector == 16'h0022 && $stable(globalMask))
		else $error("soft trap touched the mask or vector");
	chk_ack_ready: assert property (
		ackValid |-> $past(coreReady))
		else $error("ack issued while the core was busy");
	// Main scenarios seen at least once
	cov_line: cover property (vectorCall);
	cov_nmi: cover property (ackValid && ackRank == 4'h3);
	cov_trap: cover property (ackValid && ackRank == 4'hF);
	cov_reset: cover property (ackValid && ackRank == 4'h1);
endmodule : tlia_arbiter_monitor
bind tlia_arbiter tlia_arbiter_monitor i_tlia_arbiter_monitor (.core_clk,
	.reset, .coreReady, .ackValid, .ackVector, .ackRank, .vectorCall,
	.linePending, .globalMask);
`default_nettype wire

//--- bench/tlia_core_model.sv
// Purpose: Behavioural core that takes acks promptly or slowly.
// Assumes: Slow mode accepts an ack on one edge in four.
// Notes:   Ready ignores the arbiter, as a busy core would.
`timescale 1ns/100ps
`default_nettype none
module tlia_core_model (
	input  wire logic core_clk,  // Clock
	input  wire logic reset,     // Reset
	input  wire logic slow,      // Slow acceptance
	output logic      coreReady  // Core can take an ack
);
	logic [1:0] phase;
	// Free running phase paces the slow mode
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	// Busy three cycles of four so acks must wait
	assign coreReady = !slow || (phase == 2'h3);
endmodule : tlia_core_model
`default_nettype wire

//--- bench/tlia_arbiter_tb_top.sv
// Purpose: Self-checking bench of the two-level interrupt arbiter.
// Assumes: Core model answers acks; bench drives sources and APB.
// Notes:   Register numbers are word indices, byte address index * 4.
`include "tlia_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tlia_arbiter_tb_top;
	logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
	logic        nmiRequestN, emuTrap, softTrap, nmiReturn, coreReady;
	logic        ackValid, vectorCall, globalMask, slow, rdErr;
	logic        gotCall, gotMask;
	logic [31:0] paddr, pwdata, prdata, rdData;
	logic [15:0] ackVector, gotVec;
	logic [7:0]  sourceRequest;
	logic [5:0]  linePending;
	logic [4:0]  lineRequest;
	logic [3:0]  ackRank, gotRank;
	int          n_errors = 0, samples_checked = 0, nAck = 0, nWant = 0;
	typedef struct packed {logic [2:0] src; logic [15:0] ofs;} tlia_row_s;
	tlia_row_s   rows [8];

	tlia_arbiter i_tlia_arbiter (.core_clk, .reset, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sourceRequest, .nmiRequestN, .lineRequest, .emuTrap, .softTrap,
		.nmiReturn, .coreReady, .ackValid, .ackVector, .ackRank,
		.vectorCall, .linePending, .globalMask);
	tlia_core_model i_tlia_core_model (.core_clk, .reset, .slow, .coreReady);

	// Clock, 5 ns period
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Record each ack the way the core takes it
	always @(posedge core_clk) begin
		if (ackValid === 1'b1) begin
			nAck <= nAck + 1;
			gotVec <= ackVector;
			gotRank <= ackRank;
			gotCall <= vectorCall;
			gotMask <= globalMask;
		end
	end

	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	task automatic cmp(input string what, input logic [15:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic tmo(input string what);
		n_errors++;
		$display("BAD %s expected answer seen timeout", what);
		close_out();
	endtask : tmo

	// One APB transfer; waits for pready only a bounded time
	task automatic apb(input logic w, input logic [15:0] ix, d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {14'h0, ix, 2'h0};
		pwdata <= {16'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			tmo("pready");
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [15:0] ix, exp, input string what);
		apb(1'b0, ix, 16'h0);
		cmp(what, exp, rdData[15:0]);
	endtask : rdc

	// Wait for the next ack and check what it carried
	task automatic ack(input logic [3:0] rk, input logic [15:0] vec);
		int k;
		nWant++;
		k = 0;
		while (nAck < nWant && k < 60) begin
			@(posedge core_clk);
			k++;
		end
		if (nAck < nWant)
			tmo("ack");
		cmp("rank", {12'h0, rk}, {12'h0, gotRank});
		cmp("vector", vec, gotVec);
		cmp("call", {15'h0, rk >= 4'h4 && rk <= 4'h9}, {15'h0, gotCall});
		cmp("gmask", {15'h0, rk != 4'hF}, {15'h0, gotMask});
	endtask : ack

	task automatic quiet;
		repeat (12) @(posedge core_clk);
		cmp("ack count", nWant[15:0], nAck[15:0]);
	endtask : quiet

	initial begin
		reset = 1'b1;
		nmiRequestN = 1'b1;
		{psel, penable, pwrite, emuTrap, softTrap, nmiReturn, slow} = 7'h00;
		{paddr, pwdata, sourceRequest, lineRequest} = 77'h0;
		rows = '{'{3'h0, `TLIA_OFS_EXT1}, '{3'h1, `TLIA_OFS_EXT2},
			'{3'h2, `TLIA_OFS_EXT3}, '{3'h3, `TLIA_OFS_SPI}, '{3'h4, `TLIA_OFS_RX},
			'{3'h5, `TLIA_OFS_TX}, '{3'h6, `TLIA_OFS_WDT}, '{3'h7, `TLIA_OFS_PDP}};
		repeat (2) @(posedge core_clk);
		cmp("reset gmask", 16'h1, {15'h0, globalMask});
		cmp("reset pending", 16'h0, {10'h0, linePending});
		reset <= 1'b0;
		ack(4'h1, `TLIA_VEC_RESET);
		apb(1'b0, `TLIA_IDX_STATUS, 16'h0);
		cmp("gmask bit", 16'h1, {15'h0, rdData[`TLIA_GMASK_BIT]});
		rdc(`TLIA_IDX_MASK, 16'h0, "line mask");
		$display("test reset done");
		// Each line-one source in turn through the whole path
		apb(1'b1, `TLIA_IDX_MASK, 16'h0001);
		foreach (rows[i]) begin
			apb(1'b1, `TLIA_IDX_SRC_BASE + rows[i].src, 16'h0002);
			apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
			sourceRequest[rows[i].src] <= 1'b1;
			ack(4'h4, `TLIA_VEC_LINE_BASE);
			rdc(`TLIA_IDX_SYSVEC, rows[i].ofs, "offset");
			rdc(`TLIA_IDX_SRC_BASE + rows[i].src, 16'h2, "flag");
			sourceRequest[rows[i].src] <= 1'b0;
			apb(1'b1, `TLIA_IDX_SRC_BASE + rows[i].src, 16'h0000);
		end
		$display("test source table done");
		// Two sources at once while the line is masked, then both masks open
		apb(1'b1, `TLIA_IDX_MASK, 16'h0000);
		apb(1'b1, `TLIA_IDX_SRC_BASE, 16'h0002);
		apb(1'b1, `TLIA_IDX_SRC_BASE + 16'h2, 16'h0002);
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		sourceRequest <= 8'h05;
		quiet();
		cmp("pending", 16'h1, {10'h0, linePending});
		rdc(`TLIA_IDX_SRC_BASE, 16'h3, "flag set");
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0200);
		apb(1'b1, `TLIA_IDX_MASK, 16'h0001);
		quiet();
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		ack(4'h4, `TLIA_VEC_LINE_BASE);
		rdc(`TLIA_IDX_SYSVEC, `TLIA_OFS_EXT1, "first source");
		rdc(`TLIA_IDX_SYSVEC, `TLIA_OFS_EXT3, "next source");
		rdc(`TLIA_IDX_SYSVEC, `TLIA_OFS_PHANTOM, "phantom");
		sourceRequest <= 8'h00;
		$display("test masking done");
		// Lines two and six pend together; slow core takes them in rank
		slow <= 1'b1;
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0200);
		apb(1'b1, `TLIA_IDX_MASK, 16'h003F);
		lineRequest <= 5'h11;
		quiet();
		cmp("pending lines", 16'h0022, {10'h0, linePending});
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		ack(4'h5, 16'h0004);
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		ack(4'h9, 16'h000C);
		lineRequest <= 5'h00;
		slow <= 1'b0;
		$display("test line order done");
		// Nonmaskable beats the mask, and waits while one is in service
		nmiRequestN <= 1'b0;
		ack(4'h3, `TLIA_VEC_NMI);
		rdc(`TLIA_IDX_SYSVEC, `TLIA_OFS_NMI, "nmi offset");
		nmiRequestN <= 1'b1;
		repeat (4) @(posedge core_clk);
		nmiRequestN <= 1'b0;
		quiet();
		nmiReturn <= 1'b1;
		@(posedge core_clk);
		nmiReturn <= 1'b0;
		ack(4'h3, `TLIA_VEC_NMI);
		nmiRequestN <= 1'b1;
		$display("test nonmaskable done");
		// Soft trap keeps the mask open; emulator trap vector
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		softTrap <= 1'b1;
		@(posedge core_clk);
		softTrap <= 1'b0;
		ack(4'hF, `TLIA_VEC_TRAP);
		emuTrap <= 1'b1;
		@(posedge core_clk);
		emuTrap <= 1'b0;
		ack(4'h2, `TLIA_VEC_EMU);
		$display("test traps done");
		// Unmapped place and a write to the read-only vector register
		apb(1'b0, 16'h7100, 16'h0);
		cmp("unmapped error", 16'h1, {15'h0, rdErr});
		apb(1'b1, `TLIA_IDX_SYSVEC, 16'h1234);
		cmp("read-only error", 16'h1, {15'h0, rdErr});
		$display("test bus errors done");
		// Software clears of a source flag and of a pending line
		apb(1'b1, `TLIA_IDX_SRC_BASE + 16'h3, 16'h0002);
		sourceRequest <= 8'h08;
		quiet();
		rdc(`TLIA_IDX_SRC_BASE + 16'h3, 16'h3, "spi flag");
		apb(1'b1, `TLIA_IDX_SRC_BASE + 16'h3, 16'h0003);
		rdc(`TLIA_IDX_SRC_BASE + 16'h3, 16'h2, "flag cleared");
		rdc(`TLIA_IDX_PEND, 16'h1, "pend reg");
		apb(1'b1, `TLIA_IDX_PEND, 16'h0001);
		rdc(`TLIA_IDX_PEND, 16'h0, "pend cleared");
		sourceRequest <= 8'h00;
		$display("test software clears done");
		// Reset in mid-run closes the mask and brings a reset ack again
		apb(1'b1, `TLIA_IDX_STATUS, 16'h0000);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		cmp("mid gmask", 16'h1, {15'h0, globalMask});
		cmp("mid pending", 16'h0, {10'h0, linePending});
		reset <= 1'b0;
		ack(4'h1, `TLIA_VEC_RESET);
		rdc(`TLIA_IDX_MASK, 16'h0, "mask after reset");
		$display("test mid reset done");
		close_out();
	end
endmodule : tlia_arbiter_tb_top
`default_nettype wire
